// [rtl/dacr_pkg.sv]
// Purpose: Shared constants and carriers for the converter control block.
// Assumes: AHB-Lite access, one 32-bit word per register index.
// Notes:   Byte address of a register is four times its index.
package dacr_pkg;

    // Register indices; byte address is index times four.
    localparam logic [5:0] CTRL_INDEX = 6'h00;
    localparam logic [5:0] RSVD_INDEX = 6'h01;
    localparam logic [5:0] DATA_INDEX = 6'h02;

    // Control register fields.
    localparam int unsigned KEEP_BIT   = 7;
    localparam int unsigned OUTPUT_BUFFER_ENABLE_BIT  = 6;
    localparam int unsigned ENABLE_BIT = 0;

    // Conversion code layout inside the 16-bit data register.
    localparam int unsigned CODE_W   = 10;
    localparam int unsigned CODE_LSB = 6;

    // Reset values.
    localparam logic [7:0]  CTRL_RESET = 8'h00;
    localparam logic [15:0] DATA_RESET = 16'h0000;

    // AHB encodings used by the slave.
    localparam logic [2:0] SIZE_BYTE = 3'h0;
    localparam logic [2:0] SIZE_HALF = 3'h1;

    typedef struct packed {
        logic keepRunning;
        logic outEnable;
        logic convEnable;
    } dacr_ctrl_s;

    typedef struct packed {
        logic              enable;
        logic              bufferOn;
        logic              start;
        logic [CODE_W-1:0] code;
    } dacr_core_s;

endpackage

// [rtl/dacr_control.sv]
// Purpose: Register-side control of a 10-bit converter behind AHB-Lite.
// Assumes: Sleep inputs come from the power manager on clk_sys.
// Notes:   Reads take one wait state; writes take none.
//
// Design decision made here: the AHB-Lite interface to the registers.

`timescale 1ns/10ps
`default_nettype none

module dacr_control
    import dacr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    input  wire logic        sleepStandby,
    input  wire logic        sleepPowerDown,
    output var  dacr_core_s  core
);

    logic       wrPend;
    logic       rdPend;
    logic [5:0] aIdx;
    logic [1:0] aLane;
    logic       addrAccept;
    logic       wrCtrl;
    logic       wrLow;
    logic       wrHigh;
    logic       sleepBlock;
    logic       active;
    logic       pending;
    logic       startFire;
    logic [7:0] ctrlByte;
    logic [9:0] dataView;
    logic [31:0] readMux;
    logic [1:0] lowStage;
    logic [7:0] hiReg;
    dacr_ctrl_s ctrl;

    // Returns which of byte lanes 1 and 0 an access touches.
    function automatic logic [1:0] laneMask(
        input logic [1:0] a,
        input logic [2:0] s
    );
        logic [1:0] m;
        m = 2'b11;
        if (s == SIZE_BYTE) begin
            m = {a == 2'h1, a == 2'h0};
        end else if (s == SIZE_HALF) begin
            m = {!a[1], !a[1]};
        end
        return m;
    endfunction

    assign addrAccept = hsel && htrans[1] && hready;

    // Address phase capture and bus answer.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wrPend    <= 1'b0;
            rdPend    <= 1'b0;
            aIdx      <= 6'h00;
            aLane     <= 2'b00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end else begin
            wrPend    <= addrAccept && hwrite;
            rdPend    <= addrAccept && !hwrite;
            hreadyout <= !(addrAccept && !hwrite);
            hresp     <= 1'b0;
            hrdata    <= rdPend ? readMux : 32'h0000_0000;
            if (addrAccept) begin
                aIdx  <= haddr[7:2];
                aLane <= laneMask(haddr[1:0], hsize);
            end
        end
    end

    assign wrCtrl = wrPend && (aIdx == CTRL_INDEX) && aLane[0];
    assign wrLow  = wrPend && (aIdx == DATA_INDEX) && aLane[0];
    assign wrHigh = wrPend && (aIdx == DATA_INDEX) && aLane[1];

    assign ctrlByte = {ctrl.keepRunning, ctrl.outEnable, 5'h00,
                       ctrl.convEnable};
    assign dataView = {hiReg, lowStage};

    // Register read decode; unmapped and reserved words read zero.
    always_comb begin
        readMux = 32'h0000_0000;
        if (aIdx == CTRL_INDEX) begin
            readMux = {24'h00_0000, ctrlByte};
        end else if (aIdx == DATA_INDEX) begin
            readMux = {16'h0000, dataView, 6'h00};
        end else if (aIdx == RSVD_INDEX) begin
            readMux = 32'h0000_0000;
        end else begin
            readMux = 32'h0000_0000;
        end
    end

    // Control register.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctrl.keepRunning <= CTRL_RESET[KEEP_BIT];
            ctrl.outEnable   <= CTRL_RESET[OUTPUT_BUFFER_ENABLE_BIT];
            ctrl.convEnable  <= CTRL_RESET[ENABLE_BIT];
        end else if (wrCtrl) begin
            ctrl.keepRunning <= hwdata[KEEP_BIT];
            ctrl.outEnable   <= hwdata[OUTPUT_BUFFER_ENABLE_BIT];
            ctrl.convEnable  <= hwdata[ENABLE_BIT];
        end
    end

    // Data register byte pair; the high byte commits the code.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            lowStage  <= DATA_RESET[CODE_LSB+1:CODE_LSB];
            hiReg     <= DATA_RESET[15:8];
            core.code <= DATA_RESET[15:CODE_LSB];
        end else begin
            if (wrLow) begin
                lowStage <= hwdata[CODE_LSB+1:CODE_LSB];
            end
            if (wrHigh) begin
                hiReg     <= hwdata[15:8];
                core.code <= {hwdata[15:8],
                              wrLow ? hwdata[CODE_LSB+1:CODE_LSB]
                                    : lowStage};
            end
        end
    end

    // Standby without keep-running, or power-down, shuts the core off.
    assign sleepBlock = sleepPowerDown
                      || (sleepStandby && !ctrl.keepRunning);
    assign active     = ctrl.convEnable && !sleepBlock;
    assign startFire  = pending && active;

    // A committed code waits here until the converter is running.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pending <= 1'b0;
        end else if (wrHigh) begin
            pending <= 1'b1;
        end else if (startFire) begin
            pending <= 1'b0;
        end
    end

    // Signals to the analog core and its pin buffer.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            core.enable   <= 1'b0;
            core.bufferOn <= 1'b0;
            core.start    <= 1'b0;
        end else begin
            core.enable   <= active;
            core.bufferOn <= active && ctrl.outEnable;
            core.start    <= startFire;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    keep_running_a: assert property (
        sleepStandby && !sleepPowerDown && ctrl.keepRunning
        && ctrl.convEnable |=> core.enable
    ) else $error("Converter stopped in standby with keep-running set.");

    buffer_on_a: assert property (
        ctrl.outEnable && ctrl.convEnable && !sleepStandby
        && !sleepPowerDown |=> core.bufferOn
    ) else $error("Buffer off although enabled.");

    enable_write_a: assert property (
        wrCtrl && hwdata[ENABLE_BIT]
        ##1 (!sleepStandby && !sleepPowerDown) |=> core.enable
    ) else $error("Enable write did not enable the converter.");

    disable_write_a: assert property (
        wrCtrl && !hwdata[ENABLE_BIT] |=> ##1 !core.enable
    ) else $error("Disable write left the converter running.");

    byte_pair_a: assert property (
        rdPend && (aIdx == DATA_INDEX)
        |=> hrdata[15:CODE_LSB] == $past(dataView)
    ) else $error("Data read does not show the byte pair.");

    high_commit_a: assert property (
        !wrHigh |=> core.code == $past(core.code)
    ) else $error("Code changed without a high byte write.");

    code_field_a: assert property (
        wrHigh |=> core.code[9:2] == $past(hwdata[15:8])
    ) else $error("Committed code does not match data bits 15:8.");

    reset_zero_a: assert property (
        $rose(reset_n) |-> ctrlByte == CTRL_RESET && !core.enable
        && !core.bufferOn && core.code == 10'h000
    ) else $error("Registers not zero after reset.");

    start_now_a: assert property (
        wrHigh ##1 active |=> core.start
    ) else $error("Data write while enabled did not start.");

    start_held_a: assert property (
        !active |=> !core.start
    ) else $error("Conversion started while disabled.");

    standby_off_a: assert property (
        sleepStandby && !ctrl.keepRunning
        |=> !core.enable && !core.bufferOn
    ) else $error("Core left on in standby.");

    powerdown_off_a: assert property (
        sleepPowerDown |=> !core.enable && !core.bufferOn
    ) else $error("Core left on in power-down.");

    reserved_zero_a: assert property (
        rdPend |=> hrdata[31:16] == 16'h0000 && hrdata[5:1] == 5'h00
    ) else $error("Unused bits read nonzero.");

    read_wait_a: assert property (
        addrAccept && !hwrite |=> !hreadyout ##1 hreadyout
    ) else $error("Read did not take exactly one wait state.");

    write_nowait_a: assert property (
        addrAccept && hwrite |=> hreadyout
    ) else $error("Write inserted a wait state.");

    low_staged_a: assert property (
        wrLow && !wrHigh |=> core.code == $past(core.code)
    ) else $error("Low byte write changed the committed code.");

    low_bits_a: assert property (
        wrLow |=> lowStage == $past(hwdata[CODE_LSB+1:CODE_LSB])
    ) else $error("Low data bits not stored.");

    buffer_needs_a: assert property (
        core.bufferOn |-> core.enable
    ) else $error("Buffer on while converter off.");

    wake_restore_a: assert property (
        $fell(sleepStandby) && ctrl.convEnable && !sleepPowerDown
        |=> core.enable
    ) else $error("Converter not restored on wake.");

    ctrl_readback_a: assert property (
        rdPend && (aIdx == CTRL_INDEX) |=> hrdata[7:0] == $past(ctrlByte)
    ) else $error("Control read does not show the control bits.");

    pending_start_a: assert property (
        pending && active |=> core.start
    ) else $error("Pending conversion did not start.");

    unmapped_zero_a: assert property (
        rdPend && (aIdx != CTRL_INDEX) && (aIdx != DATA_INDEX)
        |=> hrdata == 32'h0000_0000
    ) else $error("Reserved word read nonzero.");

    idle_data_a: assert property (
        !rdPend |=> hrdata == 32'h0000_0000
    ) else $error("Read data shown outside a read.");

    commit_run_c: cover property (wrHigh ##1 active ##1 core.start);
    late_enable_c: cover property (
        pending && !ctrl.convEnable ##[1:20] core.start);
    standby_keep_c: cover property (
        sleepStandby && ctrl.keepRunning && core.enable);
    data_read_c: cover property (rdPend && aIdx == DATA_INDEX);

endmodule

`default_nettype wire

// [verif/dacr_core_model.sv]
// Purpose: Model of the converter core; its output pin buffer is not modelled.
// Assumes: Core link outputs are registered on clk_sys.
// Notes:   Counts conversion starts and keeps the code last converted.
`timescale 1ns/10ps
`default_nettype none
module dacr_core_model
    import dacr_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire dacr_core_s        core,
    output var  logic [7:0]        startCount,
    output var  logic [CODE_W-1:0] pinCode
);
    // A conversion takes the committed code only on a start pulse.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            startCount <= 8'h00;
            pinCode    <= '0;
        end else if (core.start === 1'b1) begin
            startCount <= startCount + 8'h01;
            pinCode    <= core.code;
        end
    end
endmodule
`default_nettype wire

// [verif/dac_control_registers_tb.sv]
// Purpose: Self-checking bench for the converter control registers.
// Assumes: Word transfers only; one slave drives the bus ready.
// Notes:   Expected values follow from the register layout.
`timescale 1ns/10ps
`default_nettype none
module dac_control_registers_tb
    import dacr_pkg::*;
;
    logic        clk_sys        = 1'b0;
    logic        reset_n        = 1'b0;
    logic        hsel           = 1'b0;
    logic [31:0] haddr          = 32'h0;
    logic [1:0]  htrans         = 2'h0;
    logic        hwrite         = 1'b0;
    logic [2:0]  hsize          = 3'h2;
    logic [31:0] hwdata         = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        sleepStandby   = 1'b0;
    logic        sleepPowerDown = 1'b0;
    dacr_core_s  core;
    logic [7:0]  startCount;
    logic [9:0]  pinCode;
    int          errors         = 0;
    int          checksDone     = 0;

    always #12.5 clk_sys = ~clk_sys;

    dacr_control u_dut (
        .clk_sys       (clk_sys),
        .reset_n       (reset_n),
        .hsel          (hsel),
        .haddr         (haddr),
        .htrans        (htrans),
        .hwrite        (hwrite),
        .hsize         (hsize),
        .hwdata        (hwdata),
        .hready        (hreadyout),
        .hreadyout     (hreadyout),
        .hresp         (hresp),
        .hrdata        (hrdata),
        .sleepStandby  (sleepStandby),
        .sleepPowerDown(sleepPowerDown),
        .core          (core)
    );

    dacr_core_model u_model (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .core      (core),
        .startCount(startCount),
        .pinCode   (pinCode)
    );

    task automatic conclude;
        $display("checks %0d, mismatches %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rdChk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, e);
        chk({31'h0, hresp}, 32'h0);
    endtask

    // Compares enable, buffer, code and the count of starts.
    task automatic coreChk(input logic [11:0] e, input logic [7:0] n);
        repeat (3) @(posedge clk_sys);
        chk({20'h0, core.enable, core.bufferOn, core.code}, {20'h0, e});
        chk({24'h0, startCount}, {24'h0, n});
    endtask

    initial begin
        #100000;
        errors++;
        conclude;
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        coreChk(12'h000, 8'h00);
        rdChk(32'h0, 32'h0);
        rdChk(32'h8, 32'h0);
        $display("test reset done");
        wr(32'h8, 32'h0000ffff);
        rdChk(32'h8, 32'h0000ffc0);
        coreChk(12'h3ff, 8'h00);
        wr(32'h0, 32'h000000ff);
        rdChk(32'h0, 32'h000000c1);
        coreChk(12'hfff, 8'h01);
        $display("test enable done");
        wr(32'h8, 32'h0000ab40);
        coreChk(12'head, 8'h02);
        chk({22'h0, pinCode}, 32'h2ad);
        $display("test commit done");
        sleepStandby <= 1'b1;
        coreChk(12'head, 8'h02);
        wr(32'h0, 32'h00000041);
        coreChk(12'h2ad, 8'h02);
        sleepStandby <= 1'b0;
        coreChk(12'head, 8'h02);
        wr(32'h0, 32'h00000081);
        coreChk(12'haad, 8'h02);
        sleepPowerDown <= 1'b1;
        coreChk(12'h2ad, 8'h02);
        sleepPowerDown <= 1'b0;
        $display("test sleep done");
        wr(32'h0, 32'h0);
        coreChk(12'h2ad, 8'h02);
        wr(32'h4, 32'hffffffff);
        rdChk(32'h4, 32'h0);
        wr(32'h3c, 32'hffffffff);
        rdChk(32'h3c, 32'h0);
        $display("test unused done");
        conclude;
    end
endmodule
`default_nettype wire
